// [common/lcr_pkg.sv]
// Constants and types of the LED channel configuration register slice
package lcr_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_RED_DUTY = 8'h04;
    localparam logic [7:0] ADDR_BLUE_SINK_LEVEL = 8'h05;
    localparam logic [7:0] ADDR_GREEN_SINK_LEVEL = 8'h06;
    localparam logic [7:0] ADDR_RED_SINK_LEVEL = 8'h07;
    localparam logic [7:0] ADDR_CHIP_SETUP = 8'h08;
    localparam logic [7:0] ADDR_SEQ1_COUNTER = 8'h09;

    // Reset values
    localparam logic [7:0] RST_RED_DUTY = 8'h00;
    localparam logic [7:0] RST_SINK_LEVEL = 8'hAF;
    localparam logic [7:0] RST_CHIP_SETUP = 8'h00;
    localparam logic [3:0] RST_SEQ1_COUNTER = 4'h0;

    // Field positions in chip_setup and seq1_counter
    localparam int FAST_DUTY_POS = 6;
    localparam int POWER_SAVE_POS = 5;
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_SRC_MSB = 1;
    localparam logic [7:0] SETUP_USED_MASK = 8'h63;
    localparam int PC_WIDTH = 4;

    // Sink current step per code, in microamps
    localparam int CURRENT_STEP_UA = 100;

    // Timing
    localparam int SYS_CLOCK_HZ = 20_000_000;
    localparam int CTRL_CLOCK_HZ = 32_768;
    localparam int SLOW_DUTY_HZ = 256;
    localparam int FAST_DUTY_HZ = 558;
    localparam int DUTY_STEPS = 256;
    localparam int PC_WRITE_GAP_US = 153;
    localparam int CTRL_TICK_CYCLES = SYS_CLOCK_HZ / CTRL_CLOCK_HZ;
    localparam int EXT_LOSS_CYCLES = 2 * CTRL_TICK_CYCLES;
    localparam int SLOW_STEP_CYCLES = SYS_CLOCK_HZ / (SLOW_DUTY_HZ * DUTY_STEPS);
    localparam int FAST_STEP_CYCLES = SYS_CLOCK_HZ / (FAST_DUTY_HZ * DUTY_STEPS);

    localparam int CTRL_DIV_W = 10;
    localparam int LOSS_W = 11;
    localparam int DUTY_DIV_W = 9;
    localparam logic [CTRL_DIV_W-1:0] CTRL_TICK_LAST = CTRL_DIV_W'(CTRL_TICK_CYCLES - 1);
    localparam logic [LOSS_W-1:0] EXT_LOSS_LAST = LOSS_W'(EXT_LOSS_CYCLES - 1);
    localparam logic [DUTY_DIV_W-1:0] SLOW_STEP_LAST = DUTY_DIV_W'(SLOW_STEP_CYCLES - 1);
    localparam logic [DUTY_DIV_W-1:0] FAST_STEP_LAST = DUTY_DIV_W'(FAST_STEP_CYCLES - 1);

    typedef enum logic [1:0] {
        CLK_SRC_EXTERNAL = 2'b00,
        CLK_SRC_INTERNAL = 2'b01,
        CLK_SRC_AUTO = 2'b10,
        CLK_SRC_INTERNAL_ALT = 2'b11
    } lcr_clk_src_e;

    typedef enum logic [1:0] {
        RUN_HOLD = 2'b00,
        RUN_STEP = 2'b01,
        RUN_FREE = 2'b10,
        RUN_ONCE = 2'b11
    } lcr_run_ctrl_e;

    typedef enum logic [1:0] {
        SRC_DIRECT = 2'b00,
        SRC_SEQ1 = 2'b01,
        SRC_SEQ2 = 2'b10,
        SRC_SEQ3 = 2'b11
    } lcr_duty_src_e;

endpackage

// [hdl/lcr_ctrl_clock.sv]
// Controller clock tick: external slow clock pin or internal divider
`timescale 1ns/1ps
`default_nettype none
module lcr_ctrl_clock
    import lcr_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic external_slow_clock,
    input wire logic [1:0] clock_source_sel,
    output logic ctrl_tick,
    output logic ext_clock_used
);

    typedef struct packed {
        logic [2:0] sync;
        logic ext_level;
        logic ext_seen;
        logic [LOSS_W-1:0] loss_cnt;
        logic [CTRL_DIV_W-1:0] int_cnt;
        logic use_ext;
        logic tick;
    } lcr_clk_state_s;

    lcr_clk_state_s s;
    lcr_clk_state_s next_s;
    logic ext_rise;
    logic int_wrap;

    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], external_slow_clock};
        ext_rise = 1'b0;
        // Only a level on which the second and third stages agree counts
        if (s.sync[1] == s.sync[2]) begin
            next_s.ext_level = s.sync[2];
            ext_rise = s.sync[2] & ~s.ext_level;
        end
        // Automatic selection drops the pin after two missing periods
        if (ext_rise) begin
            next_s.ext_seen = 1'b1;
            next_s.loss_cnt = '0;
        end else if (s.loss_cnt == EXT_LOSS_LAST) begin
            next_s.ext_seen = 1'b0;
        end else begin
            next_s.loss_cnt = s.loss_cnt + 1'b1;
        end
        int_wrap = (s.int_cnt == CTRL_TICK_LAST);
        next_s.int_cnt = int_wrap ? '0 : s.int_cnt + 1'b1;
        unique case (lcr_clk_src_e'(clock_source_sel))
            CLK_SRC_EXTERNAL: next_s.use_ext = 1'b1;
            CLK_SRC_AUTO: next_s.use_ext = s.ext_seen;
            CLK_SRC_INTERNAL, CLK_SRC_INTERNAL_ALT: next_s.use_ext = 1'b0;
        endcase
        next_s.tick = s.use_ext ? ext_rise : int_wrap;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ctrl_tick = s.tick;
    assign ext_clock_used = s.use_ext;

    a_source_select: assert property (@(posedge clock) disable iff (!resetn)
        (clock_source_sel == CLK_SRC_INTERNAL || clock_source_sel == CLK_SRC_INTERNAL_ALT)
        |=> !ext_clock_used)
        else $error("internal source selected but pin clock in use");

endmodule
`default_nettype wire

// [hdl/lcr_regs.sv]
// LED channel duty, sink level, setup and sequencer 1 counter registers
`timescale 1ns/1ps
`default_nettype none
module lcr_regs
    import lcr_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic external_slow_clock,
    input wire logic [1:0] seq1_run_control,
    input wire logic seq1_instr_busy,
    input wire logic seq1_pc_advance,
    input wire logic [1:0] red_source_select,
    input wire logic [7:0] seq1_duty,
    input wire logic [7:0] seq2_duty,
    input wire logic [7:0] seq3_duty,
    output logic [7:0] blue_sink_code,
    output logic [7:0] green_sink_code,
    output logic [7:0] red_sink_code,
    output logic red_pwm_out,
    output logic fast_duty_clock,
    output logic power_save_on,
    output logic power_save_idle,
    output logic ext_clock_used,
    output logic ctrl_tick,
    output logic [3:0] seq1_counter_value,
    output logic seq1_halted,
    output logic seq1_pc_pending
);

    typedef struct packed {
        logic [7:0] red_duty;
        logic [7:0] blue_sink_level;
        logic [7:0] green_sink_level;
        logic [7:0] red_sink_level;
        logic [7:0] chip_setup;
        logic [PC_WIDTH-1:0] seq1_counter;
        logic [PC_WIDTH-1:0] pc_shadow;
        logic pc_pending;
        logic [7:0] rdata;
        logic rvalid;
        logic [DUTY_DIV_W-1:0] duty_div;
        logic [7:0] duty_cnt;
        logic red_pwm;
        logic idle;
    } lcr_state_s;

    localparam lcr_state_s RESET_STATE = '{
        red_duty: RST_RED_DUTY,
        blue_sink_level: RST_SINK_LEVEL,
        green_sink_level: RST_SINK_LEVEL,
        red_sink_level: RST_SINK_LEVEL,
        chip_setup: RST_CHIP_SETUP,
        seq1_counter: RST_SEQ1_COUNTER,
        pc_shadow: RST_SEQ1_COUNTER,
        pc_pending: 1'b0,
        rdata: 8'h00,
        rvalid: 1'b0,
        duty_div: '0,
        duty_cnt: 8'h00,
        red_pwm: 1'b0,
        idle: 1'b0
    };

    lcr_state_s s;
    lcr_state_s next_s;
    logic halted;
    logic fast;
    logic step_last;
    logic [7:0] red_src_duty;

    lcr_ctrl_clock u_ctrl_clock (
        .clock(clock),
        .resetn(resetn),
        .external_slow_clock(external_slow_clock),
        .clock_source_sel(s.chip_setup[CLK_SRC_MSB:CLK_SRC_LSB]),
        .ctrl_tick(ctrl_tick),
        .ext_clock_used(ext_clock_used)
    );

    // Busy means the current instruction has not finished yet
    assign halted = (lcr_run_ctrl_e'(seq1_run_control) == RUN_HOLD) && !seq1_instr_busy;
    assign fast = s.chip_setup[FAST_DUTY_POS];

    always_comb begin
        next_s = s;
        next_s.rvalid = reg_read;
        next_s.rdata = 8'h00;

        // Register writes
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_RED_DUTY: next_s.red_duty = reg_wdata;
                ADDR_BLUE_SINK_LEVEL: next_s.blue_sink_level = reg_wdata;
                ADDR_GREEN_SINK_LEVEL: next_s.green_sink_level = reg_wdata;
                ADDR_RED_SINK_LEVEL: next_s.red_sink_level = reg_wdata;
                ADDR_CHIP_SETUP: next_s.chip_setup = reg_wdata & SETUP_USED_MASK;
                default: begin
                end
            endcase
        end

        // Counter update lands on the controller tick; a write in the tick cycle is applied on the next tick
        if (ctrl_tick) begin
            if (s.pc_pending) begin
                next_s.seq1_counter = s.pc_shadow;
                next_s.pc_pending = 1'b0;
            end else if (seq1_pc_advance && !halted) begin
                next_s.seq1_counter = s.seq1_counter + 1'b1;
            end
        end
        // A second write before the tick replaces the first, hence the host spacing
        if (reg_write && reg_addr == ADDR_SEQ1_COUNTER && halted) begin
            next_s.pc_shadow = reg_wdata[PC_WIDTH-1:0];
            next_s.pc_pending = 1'b1;
        end

        // Register reads, unmapped offsets answer zero
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_RED_DUTY: next_s.rdata = s.red_duty;
                ADDR_BLUE_SINK_LEVEL: next_s.rdata = s.blue_sink_level;
                ADDR_GREEN_SINK_LEVEL: next_s.rdata = s.green_sink_level;
                ADDR_RED_SINK_LEVEL: next_s.rdata = s.red_sink_level;
                ADDR_CHIP_SETUP: next_s.rdata = s.chip_setup & SETUP_USED_MASK;
                ADDR_SEQ1_COUNTER: next_s.rdata = halted ? {4'h0, s.seq1_counter} : 8'h00;
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Duty clock divider: 256 steps per duty period
        step_last = (s.duty_div == (fast ? FAST_STEP_LAST : SLOW_STEP_LAST));
        if (step_last || s.duty_div > SLOW_STEP_LAST) begin
            next_s.duty_div = '0;
            next_s.duty_cnt = s.duty_cnt + 1'b1;
        end else begin
            next_s.duty_div = s.duty_div + 1'b1;
        end

        unique case (lcr_duty_src_e'(red_source_select))
            SRC_DIRECT: red_src_duty = s.red_duty;
            SRC_SEQ1: red_src_duty = seq1_duty;
            SRC_SEQ2: red_src_duty = seq2_duty;
            SRC_SEQ3: red_src_duty = seq3_duty;
        endcase
        next_s.red_pwm = (s.duty_cnt < red_src_duty);
        // Power save may only stop the clocks when nothing is lit
        next_s.idle = s.chip_setup[POWER_SAVE_POS] && (red_src_duty == 8'h00) && halted;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    // Codes go straight to the sink DACs at 0.1 mA per step
    assign blue_sink_code = s.blue_sink_level;
    assign green_sink_code = s.green_sink_level;
    assign red_sink_code = s.red_sink_level;
    assign red_pwm_out = s.red_pwm;
    assign fast_duty_clock = s.chip_setup[FAST_DUTY_POS];
    assign power_save_on = s.chip_setup[POWER_SAVE_POS];
    assign power_save_idle = s.idle;
    assign seq1_counter_value = s.seq1_counter;
    assign seq1_halted = halted;
    assign seq1_pc_pending = s.pc_pending;

    // Checks
    logic past_first;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            past_first <= 1'b0;
        end else begin
            past_first <= 1'b1;
        end
    end

    // Cycles since the duty counter last moved, and which duty clock ran through that whole step
    logic [7:0] seen_duty_cnt;
    logic [DUTY_DIV_W-1:0] step_gap;
    logic fast_span;
    logic slow_span;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            seen_duty_cnt <= 8'h00;
            step_gap <= '0;
            fast_span <= 1'b0;
            slow_span <= 1'b0;
        end else begin
            seen_duty_cnt <= s.duty_cnt;
            if (s.duty_cnt != seen_duty_cnt) begin
                step_gap <= '0;
                fast_span <= fast_duty_clock;
                slow_span <= !fast_duty_clock;
            end else begin
                fast_span <= fast_span && fast_duty_clock;
                slow_span <= slow_span && !fast_duty_clock;
                if (step_gap != '1) begin
                    step_gap <= step_gap + 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence pc_write_held;
        reg_write && reg_addr == ADDR_SEQ1_COUNTER && halted;
    endsequence

    sequence pc_wait_tick;
        seq1_pc_pending && !ctrl_tick;
    endsequence

    a_red_duty_write: assert property (
        reg_write && reg_addr == ADDR_RED_DUTY |=> s.red_duty == $past(reg_wdata))
        else $error("red duty register not updated");

    a_blue_level_write: assert property (
        reg_write && reg_addr == ADDR_BLUE_SINK_LEVEL |=> blue_sink_code == $past(reg_wdata))
        else $error("blue sink level not updated");

    a_green_level_write: assert property (
        reg_write && reg_addr == ADDR_GREEN_SINK_LEVEL |=> green_sink_code == $past(reg_wdata))
        else $error("green sink level not updated");

    a_red_level_write: assert property (
        reg_write && reg_addr == ADDR_RED_SINK_LEVEL |=> red_sink_code == $past(reg_wdata))
        else $error("red sink level not updated");

    a_sink_code_stable: assert property (
        $changed(blue_sink_code) |-> $past(reg_write && reg_addr == ADDR_BLUE_SINK_LEVEL))
        else $error("blue sink code changed without a write");

    a_sink_reset_code: assert property (
        !past_first |-> red_sink_code == 8'hAF && green_sink_code == 8'hAF && blue_sink_code == 8'hAF)
        else $error("sink level not at reset code");

    a_duty_step_fast: assert property (
        s.duty_cnt != seen_duty_cnt && fast_span && fast_duty_clock |-> step_gap == FAST_STEP_LAST)
        else $error("fast duty step spacing wrong");

    a_duty_step_slow: assert property (
        s.duty_cnt != seen_duty_cnt && slow_span && !fast_duty_clock |-> step_gap == SLOW_STEP_LAST)
        else $error("slow duty step spacing wrong");

    a_power_save_bit: assert property (
        reg_write && reg_addr == ADDR_CHIP_SETUP |=> power_save_on == $past(reg_wdata[POWER_SAVE_POS]))
        else $error("power save bit not taken");

    a_pc_held_until: assert property (
        pc_write_held ##1 pc_wait_tick |=> $stable(seq1_counter_value))
        else $error("counter changed before controller tick");

    a_pc_applied: assert property (
        seq1_pc_pending && ctrl_tick && !(reg_write && reg_addr == ADDR_SEQ1_COUNTER)
        |=> seq1_counter_value == $past(s.pc_shadow) && !seq1_pc_pending)
        else $error("pending counter value not applied on tick");

    a_pc_read_hold: assert property (
        reg_read && reg_addr == ADDR_SEQ1_COUNTER && !halted |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("counter readable outside hold");

    a_unused_bits_zero: assert property (
        reg_read && (reg_addr == ADDR_CHIP_SETUP || reg_addr == ADDR_SEQ1_COUNTER)
        |=> (reg_rdata & (($past(reg_addr) == ADDR_CHIP_SETUP) ? ~SETUP_USED_MASK : 8'hF0)) == 8'h00)
        else $error("unused bits read nonzero");

    a_red_source_mux: assert property (
        red_source_select == SRC_SEQ2 && $stable(red_source_select) && $stable(seq2_duty)
        && $stable(s.duty_cnt) |=> red_pwm_out == ($past(s.duty_cnt) < $past(seq2_duty)))
        else $error("red output not following selected source");

    a_hold_stops_count: assert property (
        seq1_run_control == RUN_HOLD && !seq1_instr_busy && ctrl_tick && !seq1_pc_pending
        |=> $stable(seq1_counter_value))
        else $error("counter moved while sequencer held");

    a_fast_bit_write: assert property (
        reg_write && reg_addr == ADDR_CHIP_SETUP |=> fast_duty_clock == $past(reg_wdata[FAST_DUTY_POS]))
        else $error("duty clock select bit not taken");

    a_pc_write_refused: assert property (
        reg_write && reg_addr == ADDR_SEQ1_COUNTER && !halted && !seq1_pc_pending |=> !seq1_pc_pending)
        else $error("counter write taken outside hold");

    a_setup_bits_masked: assert property (
        reg_write && reg_addr == ADDR_CHIP_SETUP |=> (s.chip_setup & ~SETUP_USED_MASK) == 8'h00)
        else $error("unused setup bits stored");

endmodule
`default_nettype wire

// [sim/lcr_host_model.sv]
// Host model: byte writes and reads on the decoded register port
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model
    import lcr_pkg::*;
(
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    realtime last_pc_write = -1.0e9;

    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released address and data show the inverse, so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_SEQ1_COUNTER) begin
            while ($realtime - last_pc_write <= PC_WRITE_GAP_US * 1000.0) @(posedge clock);
            last_pc_write = $realtime;
        end
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the LED channel register slice
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lcr_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rd;} lcr_row_s;
    logic clock, resetn, reg_write, reg_read, reg_rvalid, external_slow_clock, ext_run;
    logic seq1_instr_busy, seq1_pc_advance, red_pwm_out, fast_duty_clock, power_save_on;
    logic power_save_idle, ext_clock_used, ctrl_tick, seq1_halted, seq1_pc_pending;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, seq1_duty, seq2_duty, seq3_duty;
    logic [7:0] blue_sink_code, green_sink_code, red_sink_code;
    logic [1:0] seq1_run_control, red_source_select;
    logic [3:0] seq1_counter_value;
    int fail_count = 0;
    int compares = 0;
    int slow_div = 0;
    int highs, n;
    lcr_row_s rows [8] = '{'{8'h04, 8'hFF, 8'hFF}, '{8'h05, 8'h00, 8'h00}, '{8'h06, 8'hFF, 8'hFF},
        '{8'h07, 8'h12, 8'h12}, '{8'h08, 8'hFF, 8'h63}, '{8'h08, 8'h40, 8'h40}, '{8'h08, 8'h20, 8'h20},
        '{8'h0A, 8'h55, 8'h00}};
    logic [1:0] srcs [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

    lcr_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    lcr_regs uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .external_slow_clock(external_slow_clock), .seq1_run_control(seq1_run_control),
        .seq1_instr_busy(seq1_instr_busy), .seq1_pc_advance(seq1_pc_advance),
        .red_source_select(red_source_select), .seq1_duty(seq1_duty), .seq2_duty(seq2_duty),
        .seq3_duty(seq3_duty), .blue_sink_code(blue_sink_code), .green_sink_code(green_sink_code),
        .red_sink_code(red_sink_code), .red_pwm_out(red_pwm_out), .fast_duty_clock(fast_duty_clock),
        .power_save_on(power_save_on), .power_save_idle(power_save_idle), .ext_clock_used(ext_clock_used),
        .ctrl_tick(ctrl_tick), .seq1_counter_value(seq1_counter_value), .seq1_halted(seq1_halted),
        .seq1_pc_pending(seq1_pc_pending));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Pin clock near 32 kHz; held low while stopped
    always @(posedge clock) begin
        if (!resetn) begin
            slow_div <= 0;
            external_slow_clock <= 1'b0;
        end else if (slow_div == CTRL_TICK_CYCLES / 2 - 1) begin
            slow_div <= 0;
            external_slow_clock <= ext_run ? ~external_slow_clock : 1'b0;
        end else begin
            slow_div <= slow_div + 1;
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chk("reg_rvalid", 8'h01, {7'h00, v});
        chk("reg_rdata", exp, d);
    endtask

    // Bounded wait; leaves the bench one step after the edge that showed the tick
    task automatic wait_tick();
        n = 0;
        #1;
        while (ctrl_tick !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("ctrl_tick", 8'h01, {7'h00, ctrl_tick});
    endtask

    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        $display("[FAIL] watchdog expected done seen timeout");
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        ext_run = 1'b1;
        seq1_run_control = RUN_HOLD;
        seq1_instr_busy = 1'b0;
        seq1_pc_advance = 1'b0;
        red_source_select = SRC_DIRECT;
        seq1_duty = 8'hFF;
        seq2_duty = 8'h00;
        seq3_duty = 8'hFF;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(8'h04 + 8'(i), (i >= 1 && i <= 3) ? RST_SINK_LEVEL : 8'h00);
        chk("red_sink_code", RST_SINK_LEVEL, red_sink_code);
        $display("test reset values done");

        foreach (rows[i]) begin
            host.wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].rd);
        end
        chk("blue_sink_code", 8'h00, blue_sink_code);
        chk("green_sink_code", 8'hFF, green_sink_code);
        chk("red_sink_code", 8'h12, red_sink_code);
        chk("power_save_on", 8'h01, {7'h00, power_save_on});
        chk("fast_duty_clock", 8'h00, {7'h00, fast_duty_clock});
        $display("test register table done");

        foreach (srcs[i]) begin
            host.wr(ADDR_CHIP_SETUP, {6'h00, srcs[i]});
            repeat (1500) @(posedge clock);
            #1;
            chk("ext_clock_used", {7'h00, srcs[i] == 2'b00 || srcs[i] == 2'b10}, {7'h00, ext_clock_used});
        end
        @(posedge clock);
        ext_run <= 1'b0;
        repeat (2500) @(posedge clock);
        #1;
        chk("ext_clock_used", 8'h00, {7'h00, ext_clock_used});
        host.wr(ADDR_CHIP_SETUP, 8'h01);
        $display("test clock source done");

        host.wr(ADDR_SEQ1_COUNTER, 8'hF7);
        #1;
        chk("seq1_pc_pending", 8'h01, {7'h00, seq1_pc_pending});
        chk("seq1_counter_value", 8'h00, {4'h0, seq1_counter_value});
        wait_tick();
        @(posedge clock);
        #1;
        chk("seq1_counter_value", 8'h07, {4'h0, seq1_counter_value});
        rdchk(ADDR_SEQ1_COUNTER, 8'h07);
        @(posedge clock);
        seq1_instr_busy <= 1'b1;
        host.wr(ADDR_SEQ1_COUNTER, 8'h03);
        #1;
        chk("seq1_halted", 8'h00, {7'h00, seq1_halted});
        rdchk(ADDR_SEQ1_COUNTER, 8'h00);
        wait_tick();
        @(posedge clock);
        seq1_instr_busy <= 1'b0;
        seq1_run_control <= RUN_FREE;
        seq1_pc_advance <= 1'b1;
        wait_tick();
        @(posedge clock);
        seq1_pc_advance <= 1'b0;
        seq1_run_control <= RUN_HOLD;
        #1;
        chk("seq1_counter_value", 8'h08, {4'h0, seq1_counter_value});
        @(posedge clock);
        seq1_pc_advance <= 1'b1;
        wait_tick();
        @(posedge clock);
        seq1_pc_advance <= 1'b0;
        #1;
        chk("seq1_counter_value", 8'h08, {4'h0, seq1_counter_value});
        $display("test sequencer counter done");

        host.wr(ADDR_RED_DUTY, 8'h00);
        for (int s = 0; s < 4; s++) begin
            @(posedge clock);
            red_source_select <= 2'(s);
            highs = 0;
            repeat (1000) begin
                @(posedge clock);
                #1;
                highs += (red_pwm_out === 1'b1);
            end
            chk("red_pwm_out", {7'h00, s % 2 == 1}, {7'h00, highs > 0});
        end
        @(posedge clock);
        red_source_select <= SRC_DIRECT;
        host.wr(ADDR_CHIP_SETUP, 8'h41);
        host.wr(ADDR_RED_DUTY, 8'h01);
        #1;
        chk("fast_duty_clock", 8'h01, {7'h00, fast_duty_clock});
        n = 0;
        while (red_pwm_out !== 1'b0 && n < 40000) begin
            @(posedge clock);
            #1;
            n++;
        end
        while (red_pwm_out !== 1'b1 && n < 40000) begin
            @(posedge clock);
            #1;
            n++;
        end
        highs = 0;
        while (red_pwm_out === 1'b1 && highs < 400) begin
            @(posedge clock);
            #1;
            highs++;
        end
        chk("red_pwm_width", 8'(FAST_STEP_CYCLES), 8'(highs));
        $display("test duty source done");

        host.wr(ADDR_CHIP_SETUP, 8'h21);
        host.wr(ADDR_RED_DUTY, 8'h00);
        repeat (2) @(posedge clock);
        #1;
        chk("power_save_idle", 8'h01, {7'h00, power_save_idle});
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk("blue_sink_code", RST_SINK_LEVEL, blue_sink_code);
        rdchk(ADDR_CHIP_SETUP, RST_CHIP_SETUP);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
